//--- design/fci_defines.svh
// fci_defines.svh: offsets, fields and timing counts for the flash command host
`ifndef FCI_DEFINES_SVH
`define FCI_DEFINES_SVH
// register byte offsets on apb
`define FCI_REG_CTRL     12'h000
`define FCI_REG_ADDR     12'h004
`define FCI_REG_WDATA    12'h008
`define FCI_REG_STATUS   12'h00C
`define FCI_REG_RDATA    12'h010
`define FCI_REG_CODES    12'h014
// ctrl fields
`define FCI_CTRL_GO      0
`define FCI_CTRL_OP_LSB  1
`define FCI_CTRL_OP_MSB  3
`define FCI_CTRL_WORD    4
`define FCI_CTRL_UNPROT  5
`define FCI_CTRL_HWRST   6
// status fields
`define FCI_ST_BUSY      0
`define FCI_ST_RDY       1
`define FCI_ST_DONE      2
`define FCI_ST_FAIL      3
// codes register fields: unlock1, unlock2, erase confirm, erase setup
`define FCI_CODES_RST    32'h3055AAAA
// timing: clock period and figures in ns
`define FCI_CLK_NS       5
`define FCI_RST_LOW_NS   500
`define FCI_RST_REC_NS   50
`define FCI_RST_LONG_NS  10000
`define FCI_STROBE_NS    40
`define FCI_RD_NS        60
`define FCI_RST_LOW_CYC  ((`FCI_RST_LOW_NS + `FCI_CLK_NS - 1) / `FCI_CLK_NS)
`define FCI_RST_REC_CYC  ((`FCI_RST_REC_NS + `FCI_CLK_NS - 1) / `FCI_CLK_NS)
`define FCI_STROBE_CYC   ((`FCI_STROBE_NS + `FCI_CLK_NS - 1) / `FCI_CLK_NS)
`define FCI_RD_CYC       ((`FCI_RD_NS + `FCI_CLK_NS - 1) / `FCI_CLK_NS)
// unlock addresses (word mode)
`define FCI_UNLOCK_A1    18'h00555
`define FCI_UNLOCK_A2    18'h002AA
`endif

//--- design/fci_pkg.sv
// fci_pkg.sv: types for the flash command host
package fci_pkg;
  typedef enum logic [2:0] {
    FCI_OP_READ    = 3'h0,
    FCI_OP_PROG    = 3'h1,
    FCI_OP_BERASE  = 3'h2,
    FCI_OP_CERASE  = 3'h3,
    FCI_OP_SUSPEND = 3'h4,
    FCI_OP_RESUME  = 3'h5,
    FCI_OP_RESET   = 3'h6,
    FCI_OP_IDREAD  = 3'h7
  } fci_op_t;
  typedef enum logic [2:0] {
    FCI_S_IDLE  = 3'h0,
    FCI_S_SETUP = 3'h1,
    FCI_S_LOW   = 3'h2,
    FCI_S_HIGH  = 3'h3,
    FCI_S_READ  = 3'h4,
    FCI_S_RSTLO = 3'h5,
    FCI_S_RSTHI = 3'h6
  } fci_state_t;
endpackage

//--- design/fci_host.sv
// fci_host.sv: apb-driven host that sequences commands into the parallel flash pins
//
// Function
// [RQ1] write all four or six cycles before program/erase
// [RQ2] unlock code on cycles one, two, four, five
// [RQ3] device drops bad sequences to array read
// [RQ4] status bits readable while engine busy
// [RQ5] third cycle carries set-up; reads follow
// [RQ6] fourth cycle carries program address and data
// [RQ7] erase: unlock on four, five; confirm six
// [RQ8] block erase can be suspended and resumed
// [RQ9] power loss resets decoder to array read
// [RQ10] address latched on falling strobe edge
// [RQ11] high-voltage A9 selects identification operations
// [RQ12] command data latched on rising strobe edge
// [RQ13] status bit positions on low data byte
// [RQ14] device drives data only when selected, gated
// [RQ15] word mode upper byte ignored for commands
// [RQ16] byte mode: top data pin is address
// [RQ17] chip-select may strobe; high means standby
// [RQ18] busy rejects program/erase except suspend
// [RQ19] ready/busy high in idle, suspend, standby
// [RQ20] reset low 500ns, ready 50ns after
// [RQ21] reset during operation lasts until ready rises
// [RQ22] reset at high voltage unlocks protected blocks
// [RQ23] busy reads return status, not array
`timescale 1ns/1ps
`default_nettype none
`include "fci_defines.svh"
module fci_host (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // flash control pins
  output logic             chip_sel_n,
  output logic             out_gate_n,
  output logic             wr_strobe_n,
  output logic             hard_reset_unlock_n,
  output logic             hv_unlock_en,
  output logic             word_mode,
  output logic      [16:0] flash_addr,
  // flash data pins, msb_or_low_address is bit 15
  input  wire logic [15:0] dq_in,
  output logic      [15:0] dq_out,
  output logic      [15:0] dq_oe,
  // open-drain ready/busy from the flash
  input  wire logic        ready_busy_n
);
  import fci_pkg::*;

  fci_state_t  state_q;
  logic [31:0] ctrl_q, addr_q, wdata_q, codes_q, rdata_q;
  logic [2:0]  cyc_q, ncyc;
  logic [7:0]  cnt_q;
  logic        done_q, fail_q, busy_q;
  logic        rb_s1_q, rb_s2_q;
  logic [15:0] dq_s1_q, dq_s2_q;
  fci_op_t     op;
  logic        wr_acc, rd_setup;
  logic [17:0] cyc_addr;
  logic [15:0] cyc_data;

  assign op     = fci_op_t'(ctrl_q[`FCI_CTRL_OP_MSB:`FCI_CTRL_OP_LSB]);
  assign wr_acc = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;

  // pin inputs pass two flip-flops; first stage feeds only the second
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rb_s1_q <= 1'b1;
      rb_s2_q <= 1'b1;
      dq_s1_q <= 16'h0000;
      dq_s2_q <= 16'h0000;
    end else begin
      rb_s1_q <= ready_busy_n;
      rb_s2_q <= rb_s1_q;
      dq_s1_q <= dq_in;
      dq_s2_q <= dq_s1_q;
    end
  end

  // cycles per instruction: array reads need none, id reads three, program four, erase six
  always_comb begin
    unique case (op)
      FCI_OP_PROG:    ncyc = 3'd4; // RQ1
      FCI_OP_BERASE:  ncyc = 3'd6; // RQ1
      FCI_OP_CERASE:  ncyc = 3'd6; // RQ1
      FCI_OP_SUSPEND: ncyc = 3'd1;
      FCI_OP_RESUME:  ncyc = 3'd1;
      FCI_OP_RESET:   ncyc = 3'd1;
      FCI_OP_READ:    ncyc = 3'd0;
      FCI_OP_IDREAD:  ncyc = 3'd3; // RQ5
    endcase
  end

  // address and data for the bus cycle in progress
  always_comb begin
    cyc_addr = 18'(addr_q);
    cyc_data = 16'(wdata_q);
    if (ncyc == 3'd1) begin
      cyc_data = {8'h00, wdata_q[7:0]}; // suspend/resume/reset code given by software
    end else begin
      unique case (cyc_q)
        3'd0, 3'd3: begin
          cyc_addr = `FCI_UNLOCK_A1;
          cyc_data = {8'h00, codes_q[7:0]}; // RQ2
        end
        3'd1, 3'd4: begin
          cyc_addr = `FCI_UNLOCK_A2;
          cyc_data = {8'h00, codes_q[15:8]}; // RQ2
        end
        3'd2: begin
          cyc_addr = `FCI_UNLOCK_A1;
          cyc_data = (ncyc == 3'd6) ? {8'h00, codes_q[31:24]} : {8'h00, wdata_q[23:16]}; // RQ5
        end
        default: begin
          cyc_addr = (op == FCI_OP_CERASE) ? `FCI_UNLOCK_A1 : 18'(addr_q); // RQ7
          cyc_data = {8'h00, codes_q[23:16]}; // RQ7
        end
      endcase
      if (ncyc == 3'd4 && cyc_q == 3'd3) begin
        cyc_addr = 18'(addr_q); // RQ6
        cyc_data = wdata_q[15:0]; // RQ6
      end
      if (ncyc == 3'd6 && cyc_q == 3'd3) begin
        cyc_addr = `FCI_UNLOCK_A1; // RQ7
        cyc_data = {8'h00, codes_q[7:0]};
      end
      // the read phase of a read or id read addresses the user location
      if (cyc_q == ncyc) begin
        cyc_addr = 18'(addr_q); // RQ5
      end
    end
  end

  // sequencer: chip-select gates each write, write strobe falls and rises on the same edges as it
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= FCI_S_IDLE;
      cyc_q   <= 3'd0;
      cnt_q   <= 8'h00;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
      fail_q  <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      // clear where the snapshot is taken, so a flag raised between snapshot
      // and access is not lost; a set in the same cycle still wins below
      if (rd_setup && paddr == `FCI_REG_STATUS) begin
        done_q <= 1'b0;
        fail_q <= 1'b0;
      end
      unique case (state_q)
        FCI_S_IDLE: begin
          cyc_q <= 3'd0;
          if (wr_acc && paddr == `FCI_REG_CTRL && pwdata[`FCI_CTRL_GO]) begin
            busy_q <= 1'b1;
            cnt_q  <= 8'h00;
            if (pwdata[`FCI_CTRL_HWRST])
              state_q <= FCI_S_RSTLO;
            else if (!rb_s2_q && pwdata[`FCI_CTRL_OP_MSB:`FCI_CTRL_OP_LSB] != 3'h4
                     && pwdata[`FCI_CTRL_OP_MSB:`FCI_CTRL_OP_LSB] != 3'h0
                     && pwdata[`FCI_CTRL_OP_MSB:`FCI_CTRL_OP_LSB] != 3'h7) begin
              busy_q  <= 1'b0; // RQ18
              fail_q  <= 1'b1; // RQ18
            end else
              state_q <= FCI_S_SETUP;
          end
        end
        FCI_S_SETUP: begin
          // address settles before strobe falls
          state_q <= (op == FCI_OP_READ && cyc_q == 3'd0) || cyc_q == ncyc ? FCI_S_READ : FCI_S_LOW;
          cnt_q   <= 8'h00;
        end
        FCI_S_LOW: begin
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q == 8'(`FCI_STROBE_CYC - 1)) begin
            state_q <= FCI_S_HIGH; // RQ12
            cnt_q   <= 8'h00;
          end
        end
        FCI_S_HIGH: begin
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q == 8'(`FCI_STROBE_CYC - 1)) begin
            cyc_q   <= cyc_q + 3'd1;
            state_q <= FCI_S_SETUP;
            if (cyc_q + 3'd1 == ncyc && op != FCI_OP_IDREAD) begin
              state_q <= FCI_S_IDLE; // RQ1
              busy_q  <= 1'b0;
              done_q  <= 1'b1;
            end
          end
        end
        FCI_S_READ: begin
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q == 8'(`FCI_RD_CYC + 2)) begin
            // two extra cycles cover the input synchroniser
            rdata_q <= {16'h0000, word_mode ? dq_s2_q : {8'h00, dq_s2_q[7:0]}}; // RQ23
            state_q <= FCI_S_IDLE;
            busy_q  <= 1'b0;
            done_q  <= 1'b1;
          end
        end
        FCI_S_RSTLO: begin
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q == 8'(`FCI_RST_LOW_CYC - 1)) begin
            state_q <= FCI_S_RSTHI; // RQ20
            cnt_q   <= 8'h00;
          end
        end
        FCI_S_RSTHI: begin
          // wait recovery, then wait until ready rises (long reset)
          if (cnt_q != 8'(`FCI_RST_REC_CYC + 2))
            cnt_q <= cnt_q + 8'h01;
          else if (rb_s2_q) begin // RQ21
            state_q <= FCI_S_IDLE;
            busy_q  <= 1'b0;
            done_q  <= 1'b1;
          end
        end
        default: state_q <= FCI_S_IDLE;
      endcase
    end
  end

  // software registers; codes stay programmable since values vary by part
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q  <= 32'h00000010;
      addr_q  <= 32'h00000000;
      wdata_q <= 32'h00000000;
      codes_q <= `FCI_CODES_RST;
    end else if (wr_acc && state_q == FCI_S_IDLE) begin
      unique case (paddr)
        `FCI_REG_CTRL:  ctrl_q  <= pwdata;
        `FCI_REG_ADDR:  addr_q  <= pwdata;
        `FCI_REG_WDATA: wdata_q <= pwdata;
        `FCI_REG_CODES: codes_q <= pwdata;
        default: ;
      endcase
    end
  end

  // apb answers in the access cycle: one wait-free handshake, registered
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        unique case (paddr)
          `FCI_REG_CTRL:   prdata <= ctrl_q;
          `FCI_REG_ADDR:   prdata <= addr_q;
          `FCI_REG_WDATA:  prdata <= wdata_q;
          `FCI_REG_STATUS: prdata <= {28'h0000000, fail_q, done_q, rb_s2_q, busy_q}; // RQ4
          `FCI_REG_RDATA:  prdata <= rdata_q;
          `FCI_REG_CODES:  prdata <= codes_q;
          default: begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  // pin drivers, all from flip-flops
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      chip_sel_n          <= 1'b1;
      out_gate_n          <= 1'b1;
      wr_strobe_n         <= 1'b1;
      hard_reset_unlock_n <= 1'b0;
      hv_unlock_en        <= 1'b0;
      word_mode           <= 1'b1;
      flash_addr          <= 17'h00000;
      dq_out              <= 16'h0000;
      dq_oe               <= 16'h0000;
    end else begin
      hard_reset_unlock_n <= state_q != FCI_S_RSTLO; // RQ20
      hv_unlock_en        <= ctrl_q[`FCI_CTRL_UNPROT] && state_q != FCI_S_RSTLO; // RQ22
      word_mode           <= ctrl_q[`FCI_CTRL_WORD]; // RQ16
      chip_sel_n          <= !(state_q == FCI_S_LOW || state_q == FCI_S_READ); // RQ17
      wr_strobe_n         <= state_q != FCI_S_LOW; // RQ10
      out_gate_n          <= state_q != FCI_S_READ; // RQ14
      // width taken from ctrl, not the pin, so after a mode change the address
      // settles with the width pin and never shifts under a falling strobe
      flash_addr          <= ctrl_q[`FCI_CTRL_WORD] ? cyc_addr[16:0] : cyc_addr[17:1];
      // byte mode: top data pin carries the low address bit
      dq_out              <= ctrl_q[`FCI_CTRL_WORD] ? cyc_data : {cyc_addr[0], 7'h00, cyc_data[7:0]}; // RQ16
      if (state_q == FCI_S_LOW || state_q == FCI_S_HIGH || state_q == FCI_S_SETUP)
        dq_oe <= ctrl_q[`FCI_CTRL_WORD] ? 16'hFFFF : 16'h80FF; // RQ15
      else
        dq_oe <= ctrl_q[`FCI_CTRL_WORD] ? 16'h0000 : 16'h8000;
    end
  end

  // strobe must only fall while address has been stable a cycle
  a_strobe_addr: assert property (@(posedge core_clk) disable iff (!resetn)
    $fell(wr_strobe_n) |-> $stable(flash_addr)) else $error("address moved at strobe fall"); // RQ10
  a_read_no_drive: assert property (@(posedge core_clk) disable iff (!resetn)
    !out_gate_n |-> dq_oe[7:0] == 8'h00) else $error("host drives while device outputs"); // RQ14
  a_reset_len: assert property (@(posedge core_clk) disable iff (!resetn)
    $fell(hard_reset_unlock_n) |-> !hard_reset_unlock_n [*8]) else $error("reset pulse short"); // RQ20
  a_write_gated: assert property (@(posedge core_clk) disable iff (!resetn)
    !wr_strobe_n |-> !chip_sel_n && out_gate_n) else $error("write strobe outside select"); // RQ17

  // low time of the reset pin; saturates, and starts full so the pulse that
  // covers our own reset is not judged short
  logic [7:0] rst_low_cnt_q;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn)
      rst_low_cnt_q <= 8'hFF;
    else if (hard_reset_unlock_n)
      rst_low_cnt_q <= 8'h00;
    else if (rst_low_cnt_q != 8'hFF)
      rst_low_cnt_q <= rst_low_cnt_q + 8'h01;
  end

  // ten idle cycles: the recovery time before the flash takes new operations
  sequence s_select_idle;
    chip_sel_n [*8] ##1 chip_sel_n [*2];
  endsequence

  a_reset_width: assert property (@(posedge core_clk) disable iff (!resetn) // RQ20
    $rose(hard_reset_unlock_n) |-> rst_low_cnt_q >= 8'(`FCI_RST_LOW_CYC)) else $error("reset pulse under minimum");
  a_reset_recover: assert property (@(posedge core_clk) disable iff (!resetn) // RQ20
    $rose(hard_reset_unlock_n) |-> s_select_idle) else $error("flash selected during reset recovery");
  a_write_drive: assert property (@(posedge core_clk) disable iff (!resetn) // RQ12
    !wr_strobe_n |-> dq_oe[7:0] == 8'hFF) else $error("command byte not driven during strobe");
endmodule
`default_nettype wire

//--- tb/fci_flash_model.sv
// fci_flash_model.sv: behavioural parallel flash seen from its pins
`timescale 1ns/1ps
`default_nettype none
module fci_flash_model #(
  parameter int         BUSY_T = 400,
  parameter int         RST_T  = 2000,
  parameter logic [7:0] ID_C   = 8'h5A  // arbitrary identification value
) (
  // control pins
  input  wire logic        chip_sel_n,
  input  wire logic        out_gate_n,
  input  wire logic        wr_strobe_n,
  input  wire logic        hard_reset_unlock_n,
  input  wire logic        word_mode,
  input  wire logic [16:0] flash_addr,
  // data and ready pins
  input  wire logic [15:0] dq_bus,
  output logic      [15:0] dq_dev,
  output logic             dq_dev_oe,
  output logic             rb_pull
);
  logic [15:0] mem [logic [17:0]];
  logic [17:0] a_q;
  logic [7:0]  c;
  logic        susp = 0, idm = 0, tog = 0, ers = 0, flt = 0, last7 = 0;
  int          step = 0, busy = 0; // power-up starts in array read
  wire         wr_n = chip_sel_n | wr_strobe_n; // either strobe ends a write
  wire  [17:0] fa   = word_mode ? {1'b0, flash_addr} : {flash_addr, dq_bus[15]};
  // time base; a suspended erase holds its count
  always #5 begin
    flt = ~flt;
    if (busy > 0 && !susp) busy = busy - 1;
    if (busy == 0) ers = 0;
  end
  always @(negedge wr_n) a_q = fa;
  // command byte taken as the write ends; upper byte ignored
  always @(posedge wr_n) begin
    c = dq_bus[7:0];
    if (busy > 0) begin
      if (ers && c == 8'hB0) susp = 1;
      else if (susp && c == 8'h30) susp = 0;
    end else begin
      idm = (step == 2 && c == 8'h90); // any other byte leaves identification
      if (step == 3) begin
        mem[a_q] = word_mode ? dq_bus : {8'h00, c};
        last7 = c[7];
        busy = BUSY_T;
      end
      if (step == 6 && c == 8'h30) begin
        mem.delete();
        ers = 1;
        last7 = 1;
        busy = BUSY_T;
      end
      case (step) // a wrong byte drops back to array read
        0, 3: step = (c == 8'hAA) ? 1 : 0;
        1: step = (c == 8'h55) ? 2 : 0;
        2: step = (c == 8'hA0) ? 3 : (c == 8'h80) ? 4 : 0;
        4: step = (c == 8'hAA) ? 5 : 0;
        5: step = (c == 8'h55) ? 6 : 0;
        default: step = 0;
      endcase
    end
  end
  // reset in mid-operation reloads busy with RST_T and cancels a suspend
  always @(negedge hard_reset_unlock_n) begin
    step = 0;
    idm = 0;
    if (busy > 0) begin
      busy = RST_T;
      susp = 0;
    end
  end
  always @(negedge out_gate_n) if (busy > 0) tog = ~tog;
  assign rb_pull   = busy > 0 && !susp;
  assign dq_dev_oe = !chip_sel_n && !out_gate_n && wr_strobe_n && hard_reset_unlock_n;
  function automatic logic [15:0] rdv(input logic [17:0] a, input logic b);
    logic [15:0] v;
    v = mem.exists(a) ? mem[a] : 16'hFFFF;
    if (idm) v = {8'h00, ID_C};
    if (b) v = {{8{flt}}, ~last7, tog, 2'b00, ers, tog, 2'b00};
    if (!word_mode) v[15:8] = {8{flt}};
    return v;
  endfunction
  // released lines show a toggling pattern, never the last value
  assign dq_dev = dq_dev_oe ? rdv(fa, rb_pull) : {16{flt}};
endmodule
`default_nettype wire

//--- tb/fci_host_bench.sv
// fci_host_bench.sv: self-checking bench for the flash command host
`timescale 1ns/1ps
`default_nettype none
`include "fci_defines.svh"
module fci_host_bench;
  import fci_pkg::*;
  logic        core_clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic        cs_n, og_n, we_n, rp_n, hv, wm, dev_oe, rb_pull;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, seed;
  logic [16:0] fa;
  logic [15:0] dq_out, dq_oe, dq_dev, dat;
  logic [32:0] exp_q[$], msk_q[$];
  int          n_mismatch, samples_checked;
  wire  [15:0] dq_in = (dq_oe & dq_out) | (~dq_oe & dq_dev);
  wire         rb_n  = ~rb_pull; // open drain with pull-up

  fci_host DUT (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chip_sel_n(cs_n), .out_gate_n(og_n), .wr_strobe_n(we_n), .hard_reset_unlock_n(rp_n),
    .hv_unlock_en(hv), .word_mode(wm), .flash_addr(fa), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe), .ready_busy_n(rb_n));
  fci_flash_model #(.RST_T(200)) FLASH (.chip_sel_n(cs_n), .out_gate_n(og_n), .wr_strobe_n(we_n),
    .hard_reset_unlock_n(rp_n), .word_mode(wm), .flash_addr(fa), .dq_bus(dq_in), .dq_dev(dq_dev),
    .dq_dev_oe(dev_oe), .rb_pull(rb_pull));

  task automatic check(input logic [32:0] v, input logic [32:0] e);
    samples_checked++;
    if (v !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, v, e);
    end
  endtask
  task automatic end_of_test();
    if (n_mismatch == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one apb transfer; a read notes its masked expectation first
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] e = 0, input logic [32:0] m = 0);
    int n;
    if (!w) begin
      exp_q.push_back(e & m);
      msk_q.push_back(m);
    end
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge core_clk); n++; end while (pready !== 1'b1 && n < 40);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 40) begin n_mismatch++; end_of_test(); end
  endtask
  task automatic poll(input int b, input logic want);
    int k;
    k = 0;
    do begin apb(0, `FCI_REG_STATUS, 0); k++; end while (r[b] !== want && k < 900);
    if (k >= 900) begin n_mismatch++; end_of_test(); end
  endtask
  // x holds hardware reset, unprotect, word mode
  task automatic go(input fci_op_t op, input logic [17:0] a, input logic [31:0] wd, input logic [2:0] x);
    apb(1, `FCI_REG_ADDR, {14'h0, a});
    apb(1, `FCI_REG_WDATA, wd);
    apb(1, `FCI_REG_CTRL, {25'h0, x, op, 1'b1});
    poll(`FCI_ST_BUSY, 0);
  endtask
  // compares every read answer against the oldest note
  always @(posedge core_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
      check({pslverr, prdata} & msk_q.pop_front(), exp_q.pop_front());
  end
  initial begin
    core_clk = 0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    seed = 32'hE8A5;
    resetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    apb(0, `FCI_REG_CODES, 0, 33'(`FCI_CODES_RST), '1);
    apb(0, 12'h018, 0, 33'h100000000, '1);
    apb(1, `FCI_REG_CODES, 32'h803055AA);
    dat = 16'($random(seed));
    go(FCI_OP_PROG, 18'h01234, {16'h00A0, dat}, 3'b011);
    check(33'(r[3:2]), 33'h1);
    check(33'(hv), 33'h1);
    go(FCI_OP_PROG, 18'h00002, {16'h00A0, ~dat}, 3'b001);
    check(33'(r[`FCI_ST_FAIL]), 33'h1);
    check(33'(hv), 33'h0);
    go(FCI_OP_READ, 18'h01234, 0, 3'b001);
    apb(0, `FCI_REG_RDATA, 0, 33'({~dat[7], 7'h0}), 33'h80);
    poll(`FCI_ST_RDY, 1);
    go(FCI_OP_READ, 18'h01234, 0, 3'b001);
    apb(0, `FCI_REG_RDATA, 0, 33'(dat), 33'hFFFF);
    apb(1, `FCI_REG_CODES, 32'h803055A5);
    go(FCI_OP_PROG, 18'h00777, {16'h00A0, dat}, 3'b001);
    go(FCI_OP_READ, 18'h00777, 0, 3'b001);
    apb(0, `FCI_REG_RDATA, 0, 33'hFFFF, 33'hFFFF);
    apb(1, `FCI_REG_CODES, 32'h803055AA);
    go(FCI_OP_IDREAD, 18'h0, 32'h00900000, 3'b001);
    apb(0, `FCI_REG_RDATA, 0, 33'h5A, 33'hFF);
    go(FCI_OP_RESET, 18'h0, 32'hF0, 3'b001);
    go(FCI_OP_PROG, 18'h02B21, {24'h00A000, dat[15:8]}, 3'b000);
    poll(`FCI_ST_RDY, 1);
    go(FCI_OP_READ, 18'h02B21, 0, 3'b000);
    apb(0, `FCI_REG_RDATA, 0, 33'(dat[15:8]), 33'hFF);
    go(FCI_OP_BERASE, 18'h01234, 0, 3'b001);
    apb(0, `FCI_REG_STATUS, 0, 33'h0, 33'h2);
    go(FCI_OP_SUSPEND, 18'h0, 32'hB0, 3'b001);
    apb(0, `FCI_REG_STATUS, 0, 33'h2, 33'h2);
    go(FCI_OP_RESUME, 18'h0, 32'h30, 3'b001);
    apb(0, `FCI_REG_STATUS, 0, 33'h0, 33'h2);
    go(FCI_OP_READ, 18'h0, 0, 3'b101);
    apb(0, `FCI_REG_STATUS, 0, 33'h2, 33'hB);
    end_of_test();
  end
endmodule
`default_nettype wire
